// file: src/asrd_map.svh
// offsets, field positions, reset values and sizes of the shared ram dma block
`ifndef ASRD_MAP_SVH
`define ASRD_MAP_SVH
// ************************************************
// register offsets from the peripheral base
// ************************************************
`define ASRD_OFF_MISC       18'h00500
`define ASRD_OFF_ADDR       18'h00504
`define ASRD_OFF_COUNT      18'h00508
`define ASRD_OFF_CLKGATE    18'h00510
// ************************************************
// ram windows, selected by address bits 17:14
// ************************************************
`define ASRD_WIN_STRAIGHT   4'h8
`define ASRD_WIN_SWAPPED    4'hc
`define ASRD_RAM_BYTES      16384
`define ASRD_FIFO_DEPTH     32
// ************************************************
// field positions and writable masks
// ************************************************
`define ASRD_RAM_SIDE_ADDRESS_MSB    31
`define ASRD_RAM_SIDE_ADDRESS_LSB    18
`define ASRD_ATA_SIDE_ADDRESS_MSB    15
`define ASRD_ATA_SIDE_ADDRESS_LSB    2
`define ASRD_COUNT_MSB      15
`define ASRD_ADDR_MASK      32'hfffc_fffc
`define ASRD_COUNT_MASK     32'h0000_ffff
`define ASRD_MISC_MASK      32'h0000_0867
`define ASRD_GATE_MASK      32'h0000_0003
`define ASRD_BIT_ARM        0
`define ASRD_BIT_DIR        1
`define ASRD_BIT_IRQEN      2
`define ASRD_BIT_IRQCLR     3
`define ASRD_BIT_IRQPEND    4
`define ASRD_BIT_BORDER     6
`define ASRD_BIT_URIE       11
`define ASRD_BIT_URIC       12
`define ASRD_BIT_URIP       13
`define ASRD_BIT_USB_CLOCK_ENABLE     0
`define ASRD_BIT_CAN_CLOCK_ENABLE     1
`define ASRD_RESET_WORD     32'h0000_0000
`define ASRD_HALF_STEP      14'h0002
`endif

// file: src/asrd_pkg.sv
// types and byte-order helpers of the shared ram dma block
package asrd_pkg;
	typedef logic [17:0] asrd_cpu_addr_type;   // byte offset from peripheral base
	typedef logic [31:0] asrd_word_type;       // ram and register word
	typedef logic [15:0] asrd_half_type;       // ata data word
	typedef enum logic [0:0] {PROD_IDLE, PROD_BUSY} asrd_prod_state_type;

	// reverse the four bytes of a word
	function automatic asrd_word_type asrd_swap32(input asrd_word_type w);
		return {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction

	// reverse the two bytes of a half word
	function automatic asrd_half_type asrd_swap16(input asrd_half_type h);
		return {h[7:0], h[15:8]};
	endfunction
endpackage

// file: src/asrd_top.sv
// shared ram, three-port arbiter, ata dma engine with fifo, clock gating
// Behaviour
// - ram-side address held in bits 31..18
// - ata-side address held in bits 15..2
// - word count taken from count bits 15..0
// - can clock bit cleared stops can, sleep
// - usb clock bit cleared puts usb standby
// - 16 kbyte ram, one arbiter, three requesters
// - usb master wins the arbiter while its usb clock bit is set
// - usb master reaches only the shared ram
// - straight cpu window passes words unchanged
// - swapped cpu window reverses word bytes
// - ata-side address never changes during transfer
// - ram-side address advances every moved word
// - armed engine moves data without cpu
// - count reaching zero ends, requests interrupt
// - armed moves on ata need, disarmed never
// - byte order bit swaps ata data
// - writing one to clear drops pending
// - pending forwarded only while enabled
`timescale 1ns/100ps
`default_nettype none
`include "asrd_map.svh"

// ************************************************
// fifo between data source and destination
// ************************************************
module asrd_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = `ASRD_FIFO_DEPTH
) (
	input  wire logic                   clock,
	input  wire logic                   rstn,
	input  wire logic                   inValid,
	input  wire logic [WIDTH-1:0]       inData,
	output logic                        inReady,
	output logic                        outValid,
	output logic [WIDTH-1:0]            outData,
	input  wire logic                   outReady
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];          // storage
	logic [AW-1:0]    wrPtr_reg, wrPtr_next; // write pointer
	logic [AW-1:0]    rdPtr_reg, rdPtr_next; // read pointer
	logic [AW:0]      fill_reg, fill_next;   // entries held
	logic             push, pop;

	// structure needs a power of two
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("fifo depth must be a power of two");
	end

	assign inReady  = fill_reg != (AW+1)'(DEPTH);
	assign outValid = fill_reg != '0;
	assign outData  = mem[rdPtr_reg];
	assign push     = inValid & inReady;
	assign pop      = outValid & outReady;

	// pointer and level updates
	always_comb begin
		wrPtr_next = push ? wrPtr_reg + 1'b1 : wrPtr_reg;
		rdPtr_next = pop ? rdPtr_reg + 1'b1 : rdPtr_reg;
		fill_next  = fill_reg + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			fill_reg  <= '0;
		end else begin
			wrPtr_reg <= wrPtr_next;
			rdPtr_reg <= rdPtr_next;
			fill_reg  <= fill_next;
		end
	end

	// storage write
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wrPtr_reg] <= inData;
		end
	end
endmodule // asrd_fifo

// ************************************************
// top: registers, ram, arbiter, dma engine
// ************************************************
module asrd_top #(
	parameter int RAM_BYTES  = `ASRD_RAM_BYTES,
	parameter int FIFO_DEPTH = `ASRD_FIFO_DEPTH
) (
	input  wire logic                   clock,
	input  wire logic                   rstn,
	input  wire logic                   cpuReq,
	input  wire logic                   cpuWrite,
	input  wire asrd_pkg::asrd_cpu_addr_type cpuAddr,
	input  wire asrd_pkg::asrd_word_type cpuWdata,
	output logic                        cpuAck,
	output asrd_pkg::asrd_word_type     cpuRdata,
	input  wire logic                   usbReq,
	input  wire logic                   usbWrite,
	input  wire logic [11:0]            usbAddr,
	input  wire logic [3:0]             usbByteEn,
	input  wire asrd_pkg::asrd_word_type usbWdata,
	output logic                        usbGnt,
	output logic                        usbRvalid,
	output asrd_pkg::asrd_word_type     usbRdata,
	input  wire logic                   ataNeed,
	output logic                        ataReq,
	output logic                        ataWrite,
	output logic [15:0]                 ata_side_address,
	output asrd_pkg::asrd_half_type     ataWdata,
	input  wire logic                   ataAck,
	input  wire asrd_pkg::asrd_half_type ataRdata,
	output logic                        dmaIrq,
	input  wire logic                   usbResumeDetect,
	output logic                        usbResumeIrq,
	output logic                        usbClockEnable,
	output logic                        usbStandby,
	output logic                        canClockEnable,
	output logic                        canSleep
);
	import asrd_pkg::*;
	localparam int RIW = $clog2(RAM_BYTES / 4);

	// ram size must match the 14-bit ram-side field and usb port
	if (RAM_BYTES != 16384 || FIFO_DEPTH < 2) begin : g_chk
		$error("ram must be 16 kbyte and fifo at least two deep");
	end

	// ************************************************
	// state
	// ************************************************
	asrd_word_type       misc_reg, misc_next;         // control bits
	asrd_word_type       addr_reg, addr_next;         // address pair
	asrd_word_type       count_reg, count_next;       // word count
	asrd_word_type       gate_reg, gate_next;         // clock gating
	logic                pend_reg, pend_next;         // dma done pending
	logic                urip_reg, urip_next;         // usb resume pending
	logic [15:0]         fetch_reg, fetch_next;       // words still to fetch
	asrd_prod_state_type prod_reg, prod_next;         // source side state
	logic                half_reg, half_next;         // ram half being read
	logic                cons_reg, cons_next;         // ata write in progress
	logic                cpuAck_reg, cpuAck_next;     // cpu answer
	logic                fromRam_reg, fromRam_next;   // answer from ram
	logic                swap_reg, swap_next;         // answer byte swapped
	asrd_word_type       regData_reg, regData_next;   // register read data
	logic                usbRv_reg, usbRv_next;       // usb read answer
	asrd_word_type       ram [RAM_BYTES/4];           // shared memory
	asrd_word_type       ramQ;                        // ram read port

	// ************************************************
	// decode and arbiter
	// ************************************************
	logic          isStraight, isSwapped, isRam, regSel, regWr;
	logic          usbWin, cpuRamReq, cpuGnt, dmaRamReq, dmaGnt;
	logic          armed, dirIn, countZero, prodGo;
	logic          fifoPush, fifoPop, fifoInReady, fifoOutValid;
	asrd_half_type fifoIn, fifoOut;
	logic          ramEn, ramWe;
	logic [RIW-1:0] ramIdx;
	logic [3:0]    ramBe;
	asrd_word_type ramWd;
	logic [13:0]   ramSide;

	assign isStraight = cpuAddr[17:14] == `ASRD_WIN_STRAIGHT;
	assign isSwapped  = cpuAddr[17:14] == `ASRD_WIN_SWAPPED;
	assign isRam      = isStraight | isSwapped;
	assign regSel     = cpuReq & ~cpuAck_reg & ~isRam;
	assign regWr      = regSel & cpuWrite;
	assign cpuRamReq  = cpuReq & ~cpuAck_reg & isRam;
	assign usbWin     = usbReq & gate_reg[`ASRD_BIT_USB_CLOCK_ENABLE];
	assign cpuGnt     = cpuRamReq & ~usbWin;
	assign dmaGnt     = dmaRamReq & ~usbWin & ~cpuRamReq;
	assign usbGnt     = usbWin;
	assign ramSide    = addr_reg[`ASRD_RAM_SIDE_ADDRESS_MSB:`ASRD_RAM_SIDE_ADDRESS_LSB];

	// one ram port shared by three requesters, usb first
	always_comb begin
		ramEn  = dmaGnt;
		ramWe  = dirIn;
		ramIdx = ramSide[RIW+1:2];
		ramBe  = ramSide[1] ? 4'hc : 4'h3;
		ramWd  = {fifoOut, fifoOut};
		if (usbWin) begin
			ramEn  = 1'b1;
			ramWe  = usbWrite;
			ramIdx = usbAddr;
			ramBe  = usbByteEn;
			ramWd  = usbWdata;
		end else if (cpuGnt) begin
			ramEn  = 1'b1;
			ramWe  = cpuWrite;
			ramIdx = cpuAddr[RIW+1:2];
			ramBe  = 4'hf;
			ramWd  = isSwapped ? asrd_swap32(cpuWdata) : cpuWdata;
		end
	end

	// memory with byte lanes and registered read
	always_ff @(posedge clock) begin
		if (!rstn) begin
			ramQ <= `ASRD_RESET_WORD;
		end else if (ramEn) begin
			if (ramWe) begin
				for (int b = 0; b < 4; b++) begin
					if (ramBe[b]) begin
						ram[ramIdx][8*b +: 8] <= ramWd[8*b +: 8];
					end
				end
			end
			ramQ <= ram[ramIdx];
		end
	end

	// ************************************************
	// dma data path
	// ************************************************
	assign armed     = misc_reg[`ASRD_BIT_ARM];
	assign dirIn     = misc_reg[`ASRD_BIT_DIR];
	assign countZero = count_reg[`ASRD_COUNT_MSB:0] == 16'h0000;
	assign prodGo    = armed & (fetch_reg != 16'h0000) & fifoInReady
		& (prod_reg == PROD_IDLE);
	assign dmaRamReq = dirIn ? (armed & fifoOutValid & ~countZero) : prodGo;
	assign fifoPush  = (prod_reg == PROD_BUSY) & (~dirIn | ataAck);
	assign fifoPop   = dirIn ? dmaGnt : (cons_reg & ataAck);
	assign fifoIn    = dirIn ? (misc_reg[`ASRD_BIT_BORDER] ? asrd_swap16(ataRdata) : ataRdata)
		: (half_reg ? ramQ[31:16] : ramQ[15:0]);

	asrd_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clock    (clock),
		.rstn     (rstn),
		.inValid  (fifoPush),
		.inData   (fifoIn),
		.inReady  (fifoInReady),
		.outValid (fifoOutValid),
		.outData  (fifoOut),
		.outReady (fifoPop)
	);

	// ata side address is a register field, never stepped
	assign ata_side_address  = {addr_reg[`ASRD_ATA_SIDE_ADDRESS_MSB:`ASRD_ATA_SIDE_ADDRESS_LSB], 2'b00};
	assign ataReq   = dirIn ? (prod_reg == PROD_BUSY) : cons_reg;
	assign ataWrite = ~dirIn;
	assign ataWdata = misc_reg[`ASRD_BIT_BORDER] ? asrd_swap16(fifoOut) : fifoOut;

	// ************************************************
	// registers and engine, next values
	// ************************************************
	always_comb begin
		misc_next    = misc_reg;
		addr_next    = addr_reg;
		count_next   = count_reg;
		gate_next    = gate_reg;
		fetch_next   = fetch_reg;
		prod_next    = prod_reg;
		half_next    = half_reg;
		cons_next    = cons_reg;
		regData_next = regData_reg;
		// source side: ata read or ram read into fifo
		unique case (prod_reg)
			PROD_IDLE: begin
				if (prodGo && (dirIn ? ataNeed : dmaGnt)) begin
					prod_next  = PROD_BUSY;
					half_next  = ramSide[1];
					fetch_next = fetch_reg - 16'h0001;
				end
			end
			PROD_BUSY: begin
				if (!dirIn || ataAck) begin
					prod_next = PROD_IDLE;
				end
			end
		endcase
		// ata write from fifo head, held until acknowledged
		if (cons_reg) begin
			cons_next = ~ataAck;
		end else if (!dirIn && armed && ataNeed && fifoOutValid && !countZero) begin
			cons_next = 1'b1;
		end
		// engine ram access steps ram-side address
		if (dmaGnt) begin
			addr_next[`ASRD_RAM_SIDE_ADDRESS_MSB:`ASRD_RAM_SIDE_ADDRESS_LSB] = ramSide + `ASRD_HALF_STEP;
		end
		// destination word done
		if (fifoPop && !countZero) begin
			count_next[`ASRD_COUNT_MSB:0] = count_reg[`ASRD_COUNT_MSB:0] - 16'h0001;
		end
		// software writes win over engine updates
		if (regWr) begin
			unique case (cpuAddr)
				`ASRD_OFF_MISC:    misc_next = cpuWdata & `ASRD_MISC_MASK;
				`ASRD_OFF_ADDR:    addr_next = cpuWdata & `ASRD_ADDR_MASK;
				`ASRD_OFF_COUNT: begin
					count_next = cpuWdata & `ASRD_COUNT_MASK;
					fetch_next = cpuWdata[15:0];
				end
				`ASRD_OFF_CLKGATE: gate_next = cpuWdata & `ASRD_GATE_MASK;
				default:           misc_next = misc_reg;
			endcase
		end
		// register read data, unmapped reads zero
		if (regSel) begin
			unique case (cpuAddr)
				`ASRD_OFF_MISC: regData_next = misc_reg
					| ({31'h0, pend_reg} << `ASRD_BIT_IRQPEND)
					| ({31'h0, urip_reg} << `ASRD_BIT_URIP);
				`ASRD_OFF_ADDR:    regData_next = addr_reg;
				`ASRD_OFF_COUNT:   regData_next = count_reg;
				`ASRD_OFF_CLKGATE: regData_next = gate_reg;
				default:           regData_next = `ASRD_RESET_WORD;
			endcase
		end
	end

	// ************************************************
	// flags and answers, next values
	// ************************************************
	always_comb begin
		// done sets, clear-by-one drops, set wins
		pend_next = pend_reg;
		if (regWr && cpuAddr == `ASRD_OFF_MISC && cpuWdata[`ASRD_BIT_IRQCLR]) begin
			pend_next = 1'b0;
		end
		if (fifoPop && count_reg[`ASRD_COUNT_MSB:0] == 16'h0001) begin
			pend_next = 1'b1;
		end
		urip_next = urip_reg;
		if (regWr && cpuAddr == `ASRD_OFF_MISC && cpuWdata[`ASRD_BIT_URIC]) begin
			urip_next = 1'b0;
		end
		if (usbResumeDetect) begin
			urip_next = 1'b1;
		end
		cpuAck_next  = regSel | cpuGnt;
		fromRam_next = cpuGnt ? 1'b1 : (regSel ? 1'b0 : fromRam_reg);
		swap_next    = cpuGnt ? isSwapped : swap_reg;
		usbRv_next   = usbWin & ~usbWrite;
	end

	// ************************************************
	// state registers
	// ************************************************
	always_ff @(posedge clock) begin
		if (!rstn) begin
			misc_reg    <= `ASRD_RESET_WORD;
			addr_reg    <= `ASRD_RESET_WORD;
			count_reg   <= `ASRD_RESET_WORD;
			gate_reg    <= `ASRD_RESET_WORD;
			pend_reg    <= 1'b0;
			urip_reg    <= 1'b0;
			fetch_reg   <= 16'h0000;
			prod_reg    <= PROD_IDLE;
			half_reg    <= 1'b0;
			cons_reg    <= 1'b0;
			cpuAck_reg  <= 1'b0;
			fromRam_reg <= 1'b0;
			swap_reg    <= 1'b0;
			regData_reg <= `ASRD_RESET_WORD;
			usbRv_reg   <= 1'b0;
		end else begin
			misc_reg    <= misc_next;
			addr_reg    <= addr_next;
			count_reg   <= count_next;
			gate_reg    <= gate_next;
			pend_reg    <= pend_next;
			urip_reg    <= urip_next;
			fetch_reg   <= fetch_next;
			prod_reg    <= prod_next;
			half_reg    <= half_next;
			cons_reg    <= cons_next;
			cpuAck_reg  <= cpuAck_next;
			fromRam_reg <= fromRam_next;
			swap_reg    <= swap_next;
			regData_reg <= regData_next;
			usbRv_reg   <= usbRv_next;
		end
	end

	// ************************************************
	// outputs
	// ************************************************
	assign cpuAck         = cpuAck_reg;
	assign cpuRdata       = fromRam_reg ? (swap_reg ? asrd_swap32(ramQ) : ramQ) : regData_reg;
	assign usbRvalid      = usbRv_reg;
	assign usbRdata       = ramQ;
	assign dmaIrq         = pend_reg & misc_reg[`ASRD_BIT_IRQEN];
	assign usbResumeIrq   = urip_reg & misc_reg[`ASRD_BIT_URIE];
	assign usbClockEnable = gate_reg[`ASRD_BIT_USB_CLOCK_ENABLE];
	assign usbStandby     = ~gate_reg[`ASRD_BIT_USB_CLOCK_ENABLE];
	assign canClockEnable = gate_reg[`ASRD_BIT_CAN_CLOCK_ENABLE];
	assign canSleep       = ~gate_reg[`ASRD_BIT_CAN_CLOCK_ENABLE];

	// ************************************************
	// checks
	// ************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	sequence swapReadIssued;
		cpuGnt && !cpuWrite && isSwapped;
	endsequence
	// answer compared with the stored word, not with the read path
	sequence swapReadAnswered;
		##1 cpuAck && asrd_swap32(cpuRdata) == ram[$past(ramIdx)];
	endsequence

	usb_priority_a: assert property ((usbWin && cpuRamReq) |=> !cpuAck)
		else $error("cpu granted against usb");
	swap_read_a: assert property (swapReadIssued |-> swapReadAnswered)
		else $error("swapped read not byte reversed");
	ata_addr_fixed_a: assert property ((ataReq && !regWr) |=> $stable(ata_side_address))
		else $error("ata-side address moved");
	ram_step_a: assert property ((dmaGnt && !regWr) |=> ramSide == $past(ramSide) + 14'h0002)
		else $error("ram-side address did not step by one word");
	count_dec_a: assert property ((fifoPop && !countZero && !regWr)
		|=> count_reg[15:0] == $past(count_reg[15:0]) - 16'h0001)
		else $error("count did not drop by one");
	irq_on_zero_a: assert property ((fifoPop && count_reg[15:0] == 16'h0001)
		|=> pend_reg && countZero)
		else $error("no pending interrupt at zero count");
	disarmed_quiet_a: assert property ((!armed && prod_reg == PROD_IDLE && !cons_reg)
		|=> !fifoPush && !cons_reg)
		else $error("data moved while disarmed");
	irq_clear_a: assert property ((regWr && cpuAddr == `ASRD_OFF_MISC
		&& cpuWdata[`ASRD_BIT_IRQCLR] && !fifoPop) |=> !pend_reg && !dmaIrq)
		else $error("pending interrupt not cleared");
	can_sleep_a: assert property ((regWr && cpuAddr == `ASRD_OFF_CLKGATE
		&& !cpuWdata[`ASRD_BIT_CAN_CLOCK_ENABLE]) |=> canSleep && !canClockEnable)
		else $error("can clock not stopped");
endmodule // asrd_top
`default_nettype wire

// file: tb/asrd_ata_model.sv
// behavioural model of the ata controller side of the dma port
`timescale 1ns/100ps
`default_nettype none
module asrd_ata_model (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        needOn,
	input  wire logic        slowAck,
	output logic             ataNeed,
	input  wire logic        ataReq,
	input  wire logic        ataWrite,
	input  wire logic [15:0] ata_side_address,
	input  wire logic [15:0] ataWdata,
	output logic             ataAck,
	output logic [15:0]      ataRdata
);
	int          rdCount;     // words handed to the engine
	int          wrCount;     // words taken from the engine
	int          waitN;       // cycles the open request has waited
	logic [15:0] written [4]; // captured engine writes
	logic [15:0] lastAddr;    // address of the latest request
	// ************************************************
	// demand and answers
	// ************************************************
	// the controller asks for words only once the bench starts it
	assign ataNeed = needOn & rstn;
	// one ack pulse per request, then one idle cycle
	always @(posedge clock) begin
		ataAck <= 1'b0;
		// read data means nothing outside an ack
		ataRdata <= ~ataRdata;
		if (!rstn) begin
			rdCount  <= 0;
			wrCount  <= 0;
			waitN    <= 0;
			ataRdata <= 16'h5a5a;
		end else if (ataReq && !ataAck) begin
			// slow mode stalls three cycles
			if (waitN >= (slowAck ? 3 : 0)) begin
				ataAck   <= 1'b1;
				lastAddr <= ata_side_address;
				waitN    <= 0;
				if (ataWrite) begin
					written[wrCount[1:0]] <= ataWdata;
					wrCount               <= wrCount + 1;
				end else begin
					ataRdata <= 16'ha000 + 16'(rdCount);
					rdCount  <= rdCount + 1;
				end
			end else begin
				waitN <= waitN + 1;
			end
		end
	end
endmodule // asrd_ata_model
`default_nettype wire

// file: tb/testbench.sv
// register, window, arbiter and dma tests of the shared ram block
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import asrd_pkg::*;
	logic              clock, rstn, cpuReq, cpuWrite, cpuAck, usbReq, usbWrite, usbGnt, usbRvalid;
	logic              ataNeed, ataReq, ataWrite, ataAck, dmaIrq, needOn, slowAck, usbResumeDetect;
	logic              usbResumeIrq, usbClockEnable, usbStandby, canClockEnable, canSleep;
	asrd_cpu_addr_type cpuAddr;
	asrd_word_type     cpuWdata, cpuRdata, usbWdata, usbRdata, q;
	logic [11:0]       usbAddr;
	logic [3:0]        usbByteEn;
	logic [15:0]       ata_side_address;
	asrd_half_type     ataWdata, ataRdata;
	int                errors, total_checks, hits;
	logic [17:0]       offs [5] = '{18'h500, 18'h504, 18'h508, 18'h50c, 18'h510};
	// free running clock
	always #5 clock = ~clock;
	asrd_top #(.RAM_BYTES(16384), .FIFO_DEPTH(32)) dut_u (.clock, .rstn, .cpuReq, .cpuWrite,
		.cpuAddr, .cpuWdata, .cpuAck, .cpuRdata, .usbReq, .usbWrite, .usbAddr, .usbByteEn,
		.usbWdata, .usbGnt, .usbRvalid, .usbRdata, .ataNeed, .ataReq, .ataWrite, .ata_side_address,
		.ataWdata, .ataAck, .ataRdata, .dmaIrq, .usbResumeDetect, .usbResumeIrq,
		.usbClockEnable, .usbStandby, .canClockEnable, .canSleep);
	asrd_ata_model ata_u (.clock, .rstn, .needOn, .slowAck, .ataNeed, .ataReq, .ataWrite,
		.ata_side_address, .ataWdata, .ataAck, .ataRdata);
	// ************************************************
	// access tasks
	// ************************************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one cpu word access, request held until the ack cycle
	task automatic cpu(input logic wr, input logic [17:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		cpuReq <= 1'b1;
		cpuWrite <= wr;
		cpuAddr <= a;
		cpuWdata <= d;
		do begin
			@(posedge clock);
			#1;
			n++;
		end while (cpuAck !== 1'b1 && n < 200);
		q = cpuRdata;
		if (n >= 200) chk("cpu ack", 1, 0);
		@(posedge clock);
		cpuReq <= 1'b0;
	endtask
	task automatic rd(input logic [17:0] a, input logic [31:0] e, input string what);
		cpu(1'b0, a, 32'h0);
		chk(what, e, q);
	endtask
	// one usb master cycle, grant checked in the request cycle
	task automatic usb(input logic wr, input logic [11:0] a, input logic [3:0] be,
		input logic [31:0] d, input logic g);
		@(posedge clock);
		usbReq <= 1'b1;
		usbWrite <= wr;
		usbAddr <= a;
		usbByteEn <= be;
		usbWdata <= d;
		#1;
		chk("usb grant", g, usbGnt);
		@(posedge clock);
		usbReq <= 1'b0;
		#1;
		if (!wr) chk("usb rvalid", g, usbRvalid);
		q = usbRdata;
	endtask
	// verdict, reached from the tests and the watchdog
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge clock);
		errors++;
		report_and_stop;
	end
	// ************************************************
	// tests
	// ************************************************
	initial begin
		clock = 1'b0;
		rstn = 1'b0;
		cpuReq = 1'b0;
		cpuWrite = 1'b0;
		cpuAddr = '0;
		cpuWdata = '0;
		usbReq = 1'b0;
		usbWrite = 1'b0;
		usbAddr = '0;
		usbByteEn = '0;
		usbWdata = '0;
		needOn = 1'b0;
		slowAck = 1'b0;
		usbResumeDetect = 1'b0;
		errors = 0;
		total_checks = 0;
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		#1;
		chk("levels after reset", 3'b111, {usbStandby, canSleep, ataWrite});
		foreach (offs[i]) rd(offs[i], 32'h0, "reset value");
		usb(1'b0, 12'h0, 4'hf, 32'h0, 1'b0);
		for (int g = 0; g < 4; g++) begin
			cpu(1'b1, 18'h510, 32'(g));
			chk("gating", {g[0], ~g[0], g[1], ~g[1]},
				{usbClockEnable, usbStandby, canClockEnable, canSleep});
		end
		cpu(1'b1, 18'h504, '1);
		rd(18'h504, 32'hfffc_fffc, "address pair");
		cpu(1'b1, 18'h508, '1);
		rd(18'h508, 32'h0000_ffff, "word count");
		cpu(1'b1, 18'h508, 32'h0);
		usb(1'b1, 12'h3, 4'hf, 32'h1122_3344, 1'b1);
		usb(1'b1, 12'h3, 4'h1, 32'hffff_ff55, 1'b1);
		rd(18'h2000c, 32'h1122_3355, "straight window");
		rd(18'h3000c, 32'h5533_2211, "swapped window");
		cpu(1'b1, 18'h30010, 32'haabb_ccdd);
		usb(1'b0, 12'h4, 4'hf, 32'h0, 1'b1);
		chk("usb sees swap", 32'hddcc_bbaa, q);
		hits = 0;
		fork
			begin
				@(posedge clock);
				usbReq <= 1'b1;
				usbWrite <= 1'b0;
				repeat (6) begin
					@(posedge clock);
					#1;
					if (cpuAck === 1'b1) hits++;
				end
				@(posedge clock);
				usbReq <= 1'b0;
			end
			cpu(1'b0, 18'h20000, 32'h0);
		join
		chk("cpu waits for usb", 0, hits);
		// ata into ram, three words, irq enabled
		cpu(1'b1, 18'h500, 32'h0);
		cpu(1'b1, 18'h504, 32'h0100_00a0);
		cpu(1'b1, 18'h508, 32'h3);
		cpu(1'b1, 18'h500, 32'h6);
		needOn <= 1'b1;
		repeat (20) @(posedge clock);
		chk("no move disarmed", 0, ata_u.rdCount);
		cpu(1'b1, 18'h500, 32'h7);
		for (int n = 0; n < 400 && dmaIrq !== 1'b1; n++) @(posedge clock);
		chk("dma irq", 1, dmaIrq);
		needOn <= 1'b0;
		rd(18'h508, 32'h0, "count after");
		rd(18'h504, 32'h0118_00a0, "address after");
		chk("ata address", 16'h00a0, ata_u.lastAddr);
		rd(18'h20040, 32'ha001_a000, "words in ram");
		cpu(1'b0, 18'h20044, 32'h0);
		chk("third word", 16'ha002, q[15:0]);
		rd(18'h500, 32'h17, "pending set");
		cpu(1'b1, 18'h500, 32'he);
		rd(18'h500, 32'h6, "after clear");
		chk("irq dropped", 0, dmaIrq);
		// ram to ata, big endian, slow partner, irq masked
		cpu(1'b1, 18'h500, 32'h40);
		cpu(1'b1, 18'h504, 32'h0100_00a0);
		cpu(1'b1, 18'h508, 32'h2);
		slowAck <= 1'b1;
		needOn <= 1'b1;
		cpu(1'b1, 18'h500, 32'h41);
		for (int n = 0; n < 400 && ata_u.wrCount < 2; n++) @(posedge clock);
		repeat (4) @(posedge clock);
		rd(18'h500, 32'h51, "pending masked");
		chk("irq masked", 0, dmaIrq);
		chk("first ata word", 16'h00a0, ata_u.written[0]);
		chk("second ata word", 16'h01a0, ata_u.written[1]);
		chk("words written", 2, ata_u.wrCount);
		cpu(1'b1, 18'h500, 32'h44);
		chk("irq enabled", 1, dmaIrq);
		// usb clock off: only resume detection still raises its interrupt
		cpu(1'b1, 18'h510, 32'h0);
		cpu(1'b1, 18'h500, 32'h808);
		usb(1'b0, 12'h4, 4'hf, 32'h0, 1'b0);
		@(posedge clock);
		usbResumeDetect <= 1'b1;
		@(posedge clock);
		usbResumeDetect <= 1'b0;
		rd(18'h500, 32'h2800, "resume pending");
		chk("resume irq", 1, usbResumeIrq);
		cpu(1'b1, 18'h500, 32'h1800);
		rd(18'h500, 32'h0800, "resume cleared");
		chk("resume irq cleared", 0, usbResumeIrq);
		report_and_stop;
	end
endmodule // testbench
`default_nettype wire
